// file: hw/battery_charge_counter.sv
// Contract
// [RQ1] Signed 16-bit count follows conversion results
// [RQ2] Count readable as two's complement byte pair
// [RQ3] Raw count readable as separate byte pair
// [RQ4] 15-bit prescale steps count once per span
// [RQ5] Prescale resets to 26, host rewritable
// [RQ6] Power-up returns every element to default
// [RQ7] Clear bit self-clears after clearing count
// [RQ8] Enabled counter accumulates without pause
// [RQ9] Enable and reset each OR two bits
// [RQ10] Only initialisation is clearing to zero
// [RQ11] Sign bit set means discharging
// [RQ12] Bit 14 rising sets flag, unmasked interrupt
// [RQ13] Host clears bits 0-14 on interrupt
// [RQ14] Correction applied unless calibration disabled
// [RQ15] Dither lengthens or shortens period randomly
// [RQ16] Offset calibration shorts integrator, opens resistor
// [RQ17] Charging carry into sign sets fault
// [RQ18] Invert bit reverses counting sense
// [RQ19] Flag and mask sit in bit 2
// [RQ20] Control bit 3 enables, bit 4 resets
// [RQ21] Signed count write clears bits 0-14
`timescale 1ns/10ps
`include "battery_charge_counter_consts.svh"

module battery_charge_counter (
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic        i_conv_step,
    input  wire logic        i_conv_discharge,
    input  wire logic        i_corr_step,
    input  wire logic        i_corr_discharge,
    input  wire logic        i_period_end,
    output logic             o_irq_out_pin,
    output logic             o_integ_short,
    output logic             o_sense_disconnect,
    output logic             o_dither_extend,
    output logic             o_dither_shorten,
    output logic             o_counter_run
);

    // ************************************************************
    // Register state
    // ************************************************************
    battery_charge_counter_pkg::count_t charge_count_value;
    battery_charge_counter_pkg::count_t next_count;
    battery_charge_counter_pkg::step_t  cnt_step;
    logic               [14:0] count_prescale;
    logic signed        [16:0] pre_acc;
    logic signed        [16:0] next_pre;
    logic signed        [16:0] presc_s;
    logic                      half_scale_flag;
    logic                      half_scale_mask;
    logic               [7:0]  ctrl_reg;
    logic                      counter_clear_bit;
    logic                      alt_counter_start;
    logic                      alt_counter_reset;
    logic                      dither_enable;
    logic                      analog_offset_cal;
    logic                      count_sense_invert;
    logic                      overflow_fault_flag;
    logic                      digital_cal_disable;

    default clocking assert_cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    wire wr_irq_mask   = i_reg_wr && hit(i_reg_addr, `ADDR_IRQ_MASK);
    wire wr_ctrl       = i_reg_wr && hit(i_reg_addr, `ADDR_CTRL);
    wire wr_presc_low  = i_reg_wr && hit(i_reg_addr, `ADDR_PRESC_LOW);
    wire wr_presc_high = i_reg_wr && hit(i_reg_addr, `ADDR_PRESC_HIGH);
    wire wr_aux        = i_reg_wr && hit(i_reg_addr, `ADDR_AUX_CTRL);
    wire wr_cal        = i_reg_wr && hit(i_reg_addr, `ADDR_CAL);
    wire wr_signed     = i_reg_wr && (hit(i_reg_addr, `ADDR_CNT_HIGH) ||
                                      hit(i_reg_addr, `ADDR_CNT_LOW));
    wire rd_irq_status = i_reg_rd && hit(i_reg_addr, `ADDR_IRQ_STATUS);

    // ************************************************************
    // Counting datapath
    // ************************************************************
    // [RQ9] OR of both enables
    wire run_en    = ctrl_reg[`BIT_CNT_ENABLE] | alt_counter_start;
    // [RQ9] OR of both resets
    wire clear_req = counter_clear_bit | alt_counter_reset;
    // [RQ14] corrected stream unless bypassed
    wire sel_step  = digital_cal_disable ? i_conv_step : i_corr_step;
    wire sel_dis   = digital_cal_disable ? i_conv_discharge
                                         : i_corr_discharge;
    // [RQ11] discharge counts downward
    // [RQ18] invert flips the sense
    wire dir_up    = ~(sel_dis ^ count_sense_invert);
    wire take_step = run_en && sel_step && !clear_req;
    assign presc_s  = {2'b00, count_prescale};
    assign next_pre = dir_up ? (pre_acc + 17'sh00001)
                             : (pre_acc - 17'sh00001);
    // [RQ4] one count step per prescale span
    assign cnt_step = !take_step ? battery_charge_counter_pkg::STEP_NONE
                    : (dir_up && next_pre >= presc_s)
                      ? battery_charge_counter_pkg::STEP_UP
                    : (!dir_up && next_pre <= -presc_s)
                      ? battery_charge_counter_pkg::STEP_DOWN
                    : battery_charge_counter_pkg::STEP_NONE;
    assign next_count =
        (cnt_step == battery_charge_counter_pkg::STEP_UP)
            ? charge_count_value + 16'sh0001
        : (cnt_step == battery_charge_counter_pkg::STEP_DOWN)
            ? charge_count_value - 16'sh0001
            : charge_count_value;
    wire half_event  = (cnt_step != battery_charge_counter_pkg::STEP_NONE)
                       && next_count[14] && !charge_count_value[14]
                       && !wr_signed;
    // Carry out of 0x7FFF only; decrementing through zero is normal
    wire fault_event = (cnt_step == battery_charge_counter_pkg::STEP_UP)
                       && (charge_count_value == 16'sh7FFF)
                       && !wr_signed;
    // [RQ6] sync reset to defaults
    // [RQ10] only clearing to zero
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || clear_req) begin
            charge_count_value <= 16'sh0000;
            pre_acc            <= 17'sh00000;
        end else if (wr_signed) begin
            // [RQ21] keep sign, clear rest
            charge_count_value <= {charge_count_value[15], 15'h0000};
        end else if (take_step) begin
            // [RQ1] count follows conversions
            // [RQ8] runs while enabled
            charge_count_value <= next_count;
            pre_acc <= (cnt_step == battery_charge_counter_pkg::STEP_NONE)
                       ? next_pre : 17'sh00000;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_reg          <= 8'h00;
            counter_clear_bit <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_reg_wdata;
            end else begin
                ctrl_reg[`BIT_CNT_CLEAR] <= 1'b0;
            end
            // [RQ7] pulse of one cycle
            // [RQ20] bit 4 resets
            counter_clear_bit <= wr_ctrl && i_reg_wdata[`BIT_CNT_CLEAR];
        end
    end

    // [RQ5] prescale default and rewrite
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            count_prescale <= `PRESCALE_RESET;
        end else if (wr_presc_low) begin
            count_prescale[7:0] <= i_reg_wdata;
        end else if (wr_presc_high) begin
            count_prescale[14:8] <= i_reg_wdata[6:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            alt_counter_start   <= 1'b0;
            alt_counter_reset   <= 1'b0;
            dither_enable       <= 1'b0;
            analog_offset_cal   <= 1'b0;
            count_sense_invert  <= 1'b0;
            digital_cal_disable <= 1'b0;
            half_scale_mask     <= 1'b0;
        end else begin
            if (wr_aux) begin
                alt_counter_start  <= i_reg_wdata[`BIT_ALT_START];
                alt_counter_reset  <= i_reg_wdata[`BIT_ALT_RESET];
                dither_enable      <= i_reg_wdata[`BIT_DITHER_EN];
                analog_offset_cal  <= i_reg_wdata[`BIT_ANALOG_CAL];
                count_sense_invert <= i_reg_wdata[`BIT_INVERT];
            end
            if (wr_cal) begin
                digital_cal_disable <= i_reg_wdata[`BIT_CAL_DISABLE];
            end
            if (wr_irq_mask) begin
                half_scale_mask <= i_reg_wdata[`BIT_HALF_SCALE];
            end
        end
    end

    // ************************************************************
    // Status flags: a set in the clearing cycle wins
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            half_scale_flag     <= 1'b0;
            overflow_fault_flag <= 1'b0;
        end else begin
            // [RQ12] sticky half-scale flag
            half_scale_flag <= half_event ||
                               (half_scale_flag && !rd_irq_status);
            // [RQ17] sticky fault, no interrupt
            overflow_fault_flag <= fault_event ||
                (overflow_fault_flag &&
                 !(wr_aux && i_reg_wdata[`BIT_FAULT]));
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    wire [7:0] aux_view = {2'b00, overflow_fault_flag, count_sense_invert,
                           analog_offset_cal, dither_enable,
                           alt_counter_reset, alt_counter_start};

    // [RQ2] signed pair
    // [RQ3] raw pair
    // [RQ19] bit 2 of status and mask
    wire [7:0] rd_mux =
        hit(i_reg_addr, `ADDR_IRQ_STATUS) ? {5'h00, half_scale_flag, 2'b00}
      : hit(i_reg_addr, `ADDR_IRQ_MASK)   ? {5'h00, half_scale_mask, 2'b00}
      : hit(i_reg_addr, `ADDR_CTRL)       ? ctrl_reg
      : hit(i_reg_addr, `ADDR_CNT_HIGH)   ? charge_count_value[15:8]
      : hit(i_reg_addr, `ADDR_CNT_LOW)    ? charge_count_value[7:0]
      : hit(i_reg_addr, `ADDR_RAW_HIGH)   ? charge_count_value[15:8]
      : hit(i_reg_addr, `ADDR_RAW_LOW)    ? charge_count_value[7:0]
      : hit(i_reg_addr, `ADDR_PRESC_LOW)  ? count_prescale[7:0]
      : hit(i_reg_addr, `ADDR_PRESC_HIGH) ? {1'b0, count_prescale[14:8]}
      : hit(i_reg_addr, `ADDR_AUX_CTRL)   ? aux_view
      : hit(i_reg_addr, `ADDR_CAL)        ? {7'h00, digital_cal_disable}
      : 8'h00;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // [RQ12] masked interrupt pin
    assign o_irq_out_pin      = half_scale_flag & ~half_scale_mask;
    // [RQ16] short and disconnect
    assign o_integ_short      = analog_offset_cal;
    assign o_sense_disconnect = analog_offset_cal;
    assign o_counter_run      = run_en & ~clear_req;

    charge_dither_lfsr u_dither (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_enable     (dither_enable),
        .i_period_end (i_period_end),
        .o_extend     (o_dither_extend),
        .o_shorten    (o_dither_shorten)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_clear_written;
        wr_ctrl && i_reg_wdata[`BIT_CNT_CLEAR];
    endsequence
    sequence s_cleared;
        counter_clear_bit ##1 (!counter_clear_bit &&
                               !ctrl_reg[`BIT_CNT_CLEAR] &&
                               charge_count_value == 16'sh0000);
    endsequence
    property p_clear_self;
        s_clear_written |=> s_cleared;
    endproperty
    a_clear_self: assert property (p_clear_self) // [RQ7]
        else $error("clear bit did not clear count and itself");
    property p_step_up;
        (cnt_step == battery_charge_counter_pkg::STEP_UP && !wr_signed)
        |=> charge_count_value == $past(charge_count_value) + 16'sh0001;
    endproperty
    a_step_up: assert property (p_step_up) // [RQ1]
        else $error("count did not advance by one");
    property p_prescale_span;
        (cnt_step != battery_charge_counter_pkg::STEP_NONE && !wr_signed)
        |=> pre_acc == 17'sh00000;
    endproperty
    a_prescale_span: assert property (p_prescale_span) // [RQ4]
        else $error("prescale span did not restart after a step");
    property p_prescale_reset;
        disable iff (1'b0)
        i_sys_rst |=> count_prescale == `PRESCALE_RESET;
    endproperty
    a_prescale_reset: assert property (p_prescale_reset) // [RQ5]
        else $error("prescale did not reset to default");
    property p_or_enable;
        (alt_counter_start && !clear_req) |-> o_counter_run;
    endproperty
    a_or_enable: assert property (p_or_enable) // [RQ9]
        else $error("alternate start did not enable counter");
    property p_alt_reset;
        alt_counter_reset |=> charge_count_value == 16'sh0000;
    endproperty
    a_alt_reset: assert property (p_alt_reset) // [RQ9]
        else $error("alternate reset did not zero count");
    property p_half_irq;
        (half_event && !half_scale_mask && !wr_irq_mask)
        |=> half_scale_flag && o_irq_out_pin;
    endproperty
    a_half_irq: assert property (p_half_irq) // [RQ12]
        else $error("half scale did not raise interrupt");
    property p_fault;
        fault_event |=> overflow_fault_flag &&
                        charge_count_value == 16'sh8000;
    endproperty
    a_fault: assert property (p_fault) // [RQ17]
        else $error("overflow into sign did not set fault");
    property p_signed_write;
        (wr_signed && !clear_req) |=>
            charge_count_value[14:0] == 15'h0000 &&
            charge_count_value[15] == $past(charge_count_value[15]);
    endproperty
    a_signed_write: assert property (p_signed_write) // [RQ21]
        else $error("signed write did not keep only the sign");
    property p_analog_cal;
        (wr_aux && i_reg_wdata[`BIT_ANALOG_CAL])
        |=> o_integ_short && o_sense_disconnect;
    endproperty
    a_analog_cal: assert property (p_analog_cal) // [RQ16]
        else $error("offset calibration did not short input");

endmodule : battery_charge_counter

// file: hw/battery_charge_counter_consts.svh
`ifndef BATTERY_CHARGE_COUNTER_CONSTS_SVH
`define BATTERY_CHARGE_COUNTER_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_IRQ_STATUS    8'h5F
`define ADDR_IRQ_MASK      8'h60
`define ADDR_CTRL          8'h61
`define ADDR_CNT_HIGH      8'hC0
`define ADDR_CNT_LOW       8'hC1
`define ADDR_RAW_HIGH      8'hC2
`define ADDR_RAW_LOW       8'hC3
`define ADDR_PRESC_LOW     8'hC4
`define ADDR_PRESC_HIGH    8'hC5
`define ADDR_AUX_CTRL      8'hC6
`define ADDR_CAL           8'hC7

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_HALF_SCALE     2
`define BIT_CNT_ENABLE     3
`define BIT_CNT_CLEAR      4
`define BIT_ALT_START      0
`define BIT_ALT_RESET      1
`define BIT_DITHER_EN      2
`define BIT_ANALOG_CAL     3
`define BIT_INVERT         4
`define BIT_FAULT          5
`define BIT_CAL_DISABLE    0

// ****************************************************************
// Reset values
// ****************************************************************
`define PRESCALE_RESET     15'h001A
`define LFSR_SEED          16'hACE1

`endif

// file: hw/battery_charge_counter_pkg.sv
package battery_charge_counter_pkg;

    typedef logic signed [15:0] count_t;

    typedef enum logic [1:0] {
        STEP_NONE,
        STEP_UP,
        STEP_DOWN
    } step_t;

endpackage : battery_charge_counter_pkg

// file: hw/charge_dither_lfsr.sv
`timescale 1ns/10ps
`include "battery_charge_counter_consts.svh"

module charge_dither_lfsr #(
    parameter int                    WIDTH = 16,
    parameter logic [WIDTH-1:0]      TAPS  = 16'hB400,
    parameter logic [WIDTH-1:0]      SEED  = `LFSR_SEED
) (
    input  wire logic                i_mclk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_enable,
    input  wire logic                i_period_end,
    output logic                     o_extend,
    output logic                     o_shorten
);

    logic [WIDTH-1:0] lfsr;
    logic [WIDTH-1:0] next_lfsr;

    // Galois form: one xor row, no long feedback chain
    assign next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ TAPS) : (lfsr >> 1);

    // [RQ15] random period adjust
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            lfsr      <= SEED;
            o_extend  <= 1'b0;
            o_shorten <= 1'b0;
        end else if (!i_enable) begin
            o_extend  <= 1'b0;
            o_shorten <= 1'b0;
        end else if (i_period_end) begin
            lfsr      <= next_lfsr;
            o_extend  <= lfsr[0];
            o_shorten <= ~lfsr[0];
        end
    end

endmodule : charge_dither_lfsr

// file: testbench/host_spi_model.sv
`timescale 1ns/10ps
`include "battery_charge_counter_consts.svh"

module host_spi_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_reg_rdata,
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd
);
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
    end

    // Strobe held over exactly one rising edge, then data scrambled
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr    = 1'b1;
        @(negedge i_mclk);
        o_reg_wr    = 1'b0;
        o_reg_wdata = ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_reg_addr = a;
        o_reg_rd   = 1'b1;
        @(negedge i_mclk);
        o_reg_rd   = 1'b0;
        d          = i_reg_rdata;
    endtask : rd_reg

    task automatic clear_low_bits();
        wr_reg(`ADDR_CNT_HIGH, 8'h00);
    endtask : clear_low_bits
endmodule : host_spi_model

// file: testbench/battery_charge_counter_tb_top.sv
`timescale 1ns/10ps
`include "battery_charge_counter_consts.svh"

module battery_charge_counter_tb_top;
    logic        mclk;
    logic        sys_rst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  rdata;
    logic        conv_step;
    logic        conv_dis;
    logic        corr_step;
    logic        corr_dis;
    logic        period_end;
    logic        irq;
    logic        ishort;
    logic        sdisc;
    logic        dext;
    logic        dshort;
    logic        run;
    logic [7:0]  b;
    logic [15:0] v;
    int          num_errors;
    int          compares;

    battery_charge_counter battery_charge_counter_i (
        .i_mclk(mclk), .i_sys_rst(sys_rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata), .i_conv_step(conv_step),
        .i_conv_discharge(conv_dis), .i_corr_step(corr_step),
        .i_corr_discharge(corr_dis), .i_period_end(period_end),
        .o_irq_out_pin(irq), .o_integ_short(ishort),
        .o_sense_disconnect(sdisc), .o_dither_extend(dext),
        .o_dither_shorten(dshort), .o_counter_run(run)
    );

    host_spi_model host_spi_model_i (
        .i_mclk(mclk), .i_reg_rdata(rdata), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_spi_model_i.wr_reg(a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_spi_model_i.rd_reg(a, d);
    endtask : rd

    task automatic rd16(input logic [7:0] a, output logic [15:0] r);
        logic [7:0] h;
        logic [7:0] l;
        rd(a, h);
        rd(a + 8'h01, l);
        r = {h, l};
    endtask : rd16

    // One step pulse per rising edge for n edges
    task automatic steps(input logic raw, input logic dis, input int n);
        @(negedge mclk);
        conv_dis  = dis;
        corr_dis  = dis;
        conv_step = raw;
        corr_step = !raw;
        repeat (n) @(negedge mclk);
        conv_step = 1'b0;
        corr_step = 1'b0;
    endtask : steps

    // Clear plus enable; clear needs two edges to land
    task automatic restart();
        wr(`ADDR_CTRL, 8'h18);
        repeat (2) @(negedge mclk);
    endtask : restart

    task automatic wait_irq();
        int k;
        for (k = 0; k < 8 && irq !== 1'b1; k++) @(negedge mclk);
        if (k == 8) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_irq

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_reset();
        rd(`ADDR_PRESC_LOW, b);
        check({8'h00, b}, 16'h001A);
        rd(`ADDR_PRESC_HIGH, b);
        check({8'h00, b}, 16'h0000);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h0000);
        rd(8'hC8, b);
        check({8'h00, b}, 16'h0000);
        check({15'h0000, run}, 16'h0000);
    endtask : sc_reset

    task automatic sc_prescale();
        wr(`ADDR_PRESC_LOW, 8'h02);
        restart();
        // Clear bit must read back as zero once done
        rd(`ADDR_CTRL, b);
        check({8'h00, b}, 16'h0008);
        steps(1'b0, 1'b0, 5);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h0002);
        check({15'h0000, run}, 16'h0001);
        steps(1'b0, 1'b0, 1);
        rd16(`ADDR_RAW_HIGH, v);
        check(v, 16'h0003);
        wr(`ADDR_CTRL, 8'h00);
        steps(1'b0, 1'b0, 4);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h0003);
    endtask : sc_prescale

    task automatic sc_sign_irq();
        wr(`ADDR_PRESC_LOW, 8'h01);
        restart();
        steps(1'b0, 1'b1, 1);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'hFFFF);
        wait_irq();
        rd(`ADDR_IRQ_STATUS, b);
        check({8'h00, b}, 16'h0004);
        check({15'h0000, irq}, 16'h0000);
        restart();
        wr(`ADDR_IRQ_MASK, 8'h04);
        rd(`ADDR_IRQ_MASK, b);
        check({8'h00, b}, 16'h0004);
        steps(1'b0, 1'b1, 1);
        repeat (2) @(negedge mclk);
        check({15'h0000, irq}, 16'h0000);
        wr(`ADDR_IRQ_MASK, 8'h00);
        wait_irq();
        rd(`ADDR_IRQ_STATUS, b);
        host_spi_model_i.clear_low_bits();
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h8000);
        wr(`ADDR_AUX_CTRL, 8'h10);
        steps(1'b0, 1'b0, 1);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h7FFF);
        wr(`ADDR_AUX_CTRL, 8'h00);
    endtask : sc_sign_irq

    task automatic sc_alt_and_cal();
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_AUX_CTRL, 8'h01);
        check({15'h0000, run}, 16'h0001);
        wr(`ADDR_AUX_CTRL, 8'h03);
        @(negedge mclk);
        check({15'h0000, run}, 16'h0000);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h0000);
        wr(`ADDR_AUX_CTRL, 8'h00);
        restart();
        wr(`ADDR_CAL, 8'h01);
        steps(1'b1, 1'b0, 2);
        steps(1'b0, 1'b0, 2);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h0002);
        wr(`ADDR_CAL, 8'h00);
        steps(1'b1, 1'b0, 2);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h0002);
        wr(`ADDR_AUX_CTRL, 8'h08);
        check({14'h0000, ishort, sdisc}, 16'h0003);
        wr(`ADDR_AUX_CTRL, 8'h00);
        check({14'h0000, ishort, sdisc}, 16'h0000);
    endtask : sc_alt_and_cal

    task automatic sc_dither();
        int ne;
        ne = 0;
        wr(`ADDR_AUX_CTRL, 8'h04);
        repeat (8) begin
            period_end = 1'b1;
            @(negedge mclk);
            period_end = 1'b0;
            @(negedge mclk);
            check({15'h0000, dext ^ dshort}, 16'h0001);
            ne += dext;
        end
        // A fixed direction would not be a dither at all
        check({15'h0000, ne > 0 && ne < 8}, 16'h0001);
        wr(`ADDR_AUX_CTRL, 8'h00);
        @(negedge mclk);
        check({14'h0000, dext, dshort}, 16'h0000);
    endtask : sc_dither

    task automatic sc_fault();
        restart();
        rd(`ADDR_IRQ_STATUS, b);
        steps(1'b0, 1'b0, 16384);
        wait_irq();
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h4000);
        rd(`ADDR_IRQ_STATUS, b);
        steps(1'b0, 1'b0, 16383);
        rd(`ADDR_AUX_CTRL, b);
        check({8'h00, b}, 16'h0000);
        steps(1'b0, 1'b0, 1);
        rd(`ADDR_AUX_CTRL, b);
        check({8'h00, b}, 16'h0020);
        check({15'h0000, irq}, 16'h0000);
        rd16(`ADDR_CNT_HIGH, v);
        check(v, 16'h8000);
    endtask : sc_fault

    initial begin
        num_errors = 0;
        compares   = 0;
        sys_rst    = 1'b1;
        conv_step  = 1'b0;
        conv_dis   = 1'b0;
        corr_step  = 1'b0;
        corr_dis   = 1'b0;
        period_end = 1'b0;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        sc_reset();
        sc_prescale();
        sc_sign_irq();
        sc_alt_and_cal();
        sc_dither();
        sc_fault();
        give_verdict();
    end
endmodule : battery_charge_counter_tb_top
